// ===== core/ebt_pkg.sv
// constants and types shared by the timer files
package ebt_pkg;
  localparam int          EBT_W          = 8;
  localparam logic [7:0]  EBT_MAX        = 8'hFF;
  localparam logic [7:0]  EBT_BOTTOM     = 8'h00;
  localparam logic [7:0]  EBT_CNT_RST    = 8'h00;
  localparam logic [7:0]  EBT_CMP_RST    = 8'h00;
  // control register layout
  localparam int          EBT_CTL_CTC    = 3;
  localparam int          EBT_CTL_CS_HI  = 2;
  localparam int          EBT_CTL_CS_LO  = 0;
  localparam logic [7:0]  EBT_CTL_RST    = 8'h00;
  // flag and mask register layout
  localparam int          EBT_FLG_OVF    = 0;
  localparam int          EBT_FLG_MA     = 1;
  localparam int          EBT_FLG_MB     = 2;
  localparam logic [2:0]  EBT_FLG_RST    = 3'h0;
  // prescaler taps
  localparam int          EBT_DIV_8      = 8;
  localparam int          EBT_DIV_64     = 64;
  localparam int          EBT_DIV_256    = 256;
  localparam int          EBT_DIV_1024   = 1024;
  localparam int          EBT_PRE_W      = 10;

  typedef enum logic [2:0] {
    EBT_CS_STOP  = 3'b000,
    EBT_CS_DIV1  = 3'b001,
    EBT_CS_DIV8  = 3'b010,
    EBT_CS_DIV64 = 3'b011,
    EBT_CS_DIV256 = 3'b100,
    EBT_CS_DIV1024 = 3'b101,
    EBT_CS_EXT_FALL = 3'b110,
    EBT_CS_EXT_RISE = 3'b111
  } ebt_cs_t;
endpackage : ebt_pkg

// ===== core/ebt_edge_detect.sv
// external count pin synchroniser and edge detector
`timescale 1ns/100ps
module ebt_edge_detect (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic pin_in,
  output logic      rise_pulse,
  output logic      fall_pulse
);
  logic sync1_q;
  logic sync2_q;
  logic last_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q  <= 1'b0;
    end else if (clk_en) begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      last_q  <= sync2_q;
    end
  end

  assign rise_pulse = clk_en & sync2_q & ~last_q; // [R23]
  assign fall_pulse = clk_en & ~sync2_q & last_q; // [R23]
endmodule : ebt_edge_detect

// ===== core/ebt_prescaler.sv
// free running prescaler with divided tick taps
`timescale 1ns/100ps
module ebt_prescaler
  import ebt_pkg::*;
#(
  parameter int PRE_W = EBT_PRE_W
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  output logic      tick_div8,
  output logic      tick_div64,
  output logic      tick_div256,
  output logic      tick_div1024
);
  logic [PRE_W-1:0] pre_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pre_q <= '0;
    end else if (clk_en) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // a tap fires when the low bits below it are all ones
  assign tick_div8    = clk_en & (&pre_q[2:0]);
  assign tick_div64   = clk_en & (&pre_q[5:0]);
  assign tick_div256  = clk_en & (&pre_q[7:0]);
  assign tick_div1024 = clk_en & (&pre_q[9:0]);
endmodule : ebt_prescaler

// ===== core/ebt_timer.sv
// 8-bit timer with two compare units and three event flags
`timescale 1ns/100ps
// What this block does
// [R1] counter and two compare values are 8-bit software read/write registers
// [R2] tick source select zero gives no ticks; counter stays stopped
// [R3] select chooses prescaled clock or external pin and which pin edge
// [R4] counter read and write work whether or not ticks run
// [R5] software counter write beats increment or clear in the same cycle
// [R6] counter equal to a compare value sets that flag on next tick
// [R7] compare flag clears when its interrupt is taken
// [R8] writing one to a flag bit clears it; zero leaves it
// [R9] three requests overflow, A, B each flagged and masked separately
// [R10] counter write suppresses all matches in the following tick, even stopped
// [R11] normal mode only increments and wraps from FF to 00
// [R12] normal mode overflow set in tick counter becomes zero
// [R13] overflow flag clears when overflow interrupt is taken
// [R14] clear-on-match mode resets counter to zero at compare A match
// [R15] compare A is not buffered; below count means run through wrap
// [R16] clear-on-match mode sets overflow on FF to 00 pass
// [R17] timer runs only while its power gate bit is zero
// [R18] software should not write counter equal to a compare value
// [R19] software should take care moving compare A near zero
// [R20] select codes: 1 undivided, 2..5 div 8/64/256/1024, 6 fall, 7 rise
// [R21] pin edges count even when the pin is an output
// [R22] control holds mode in bit 3, select in bits 2:0, rest zero
// [R23] count pin synchronised and edge detected into one-cycle tick
// [R24] all logic on one clock with ticks as one-cycle enables
module ebt_timer
  import ebt_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        timer_power_gate,
  input  wire logic        external_count_pin,
  input  wire logic        ctl_wr,
  input  wire logic [7:0]  ctl_wdata,
  output logic      [7:0]  timer_control_register,
  input  wire logic        cnt_wr,
  input  wire logic [7:0]  cnt_wdata,
  output logic      [7:0]  counter_value,
  input  wire logic        cmpa_wr,
  input  wire logic [7:0]  cmpa_wdata,
  output logic      [7:0]  compare_a_value,
  input  wire logic        cmpb_wr,
  input  wire logic [7:0]  cmpb_wdata,
  output logic      [7:0]  compare_b_value,
  input  wire logic        flag_wr,
  input  wire logic [2:0]  flag_wdata,
  output logic      [2:0]  timer_flag_register,
  input  wire logic        mask_wr,
  input  wire logic [2:0]  mask_wdata,
  output logic      [2:0]  timer_mask_register,
  input  wire logic [2:0]  irq_taken,
  output logic             irq_overflow,
  output logic             irq_match_a,
  output logic             irq_match_b,
  output logic             timer_tick
);
  import ebt_pkg::*;

  logic            enable;
  logic            clear_on_match_select_q;
  ebt_cs_t         tick_source_select_q;
  logic [7:0]      cnt_q;
  logic [7:0]      cnt_d;
  logic [7:0]      cmpa_q;
  logic [7:0]      cmpb_q;
  logic [2:0]      flag_q;
  logic [2:0]      flag_d;
  logic [2:0]      mask_q;
  logic            block_q;
  logic            tick;
  logic            t8;
  logic            t64;
  logic            t256;
  logic            t1024;
  logic            pin_rise;
  logic            pin_fall;
  logic            match_a;
  logic            match_b;
  logic            ovf_evt;
  logic [2:0]      set_evt;
  logic [2:0]      clr_evt;

  assign enable = clk_en & ~timer_power_gate; // [R17]

  ebt_prescaler #(
    .PRE_W        (EBT_PRE_W)
  ) u_pre (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .clk_en       (enable),
    .tick_div8    (t8),
    .tick_div64   (t64),
    .tick_div256  (t256),
    .tick_div1024 (t1024)
  );

  // pin path ignores any port direction setting
  ebt_edge_detect u_edge (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .clk_en     (enable),
    .pin_in     (external_count_pin), // [R21]
    .rise_pulse (pin_rise), // [R23]
    .fall_pulse (pin_fall)
  );

  // tick source select
  always_comb begin
    unique case (tick_source_select_q) // [R3] [R20]
      EBT_CS_STOP:     tick = 1'b0; // [R2]
      EBT_CS_DIV1:     tick = enable;
      EBT_CS_DIV8:     tick = t8;
      EBT_CS_DIV64:    tick = t64;
      EBT_CS_DIV256:   tick = t256;
      EBT_CS_DIV1024:  tick = t1024;
      EBT_CS_EXT_FALL: tick = pin_fall;
      EBT_CS_EXT_RISE: tick = pin_rise;
    endcase
  end
  assign timer_tick = tick; // [R24]

  // control register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clear_on_match_select_q <= EBT_CTL_RST[EBT_CTL_CTC];
      tick_source_select_q    <= ebt_cs_t'(EBT_CTL_RST[EBT_CTL_CS_HI:EBT_CTL_CS_LO]);
    end else if (clk_en && ctl_wr) begin
      clear_on_match_select_q <= ctl_wdata[EBT_CTL_CTC]; // [R22]
      tick_source_select_q    <= ebt_cs_t'(ctl_wdata[EBT_CTL_CS_HI:EBT_CTL_CS_LO]);
    end
  end
  assign timer_control_register = {4'h0, clear_on_match_select_q, tick_source_select_q}; // [R22]

  // compare registers, written straight through with no buffering
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmpa_q <= EBT_CMP_RST;
      cmpb_q <= EBT_CMP_RST;
    end else if (clk_en) begin
      if (cmpa_wr) begin
        cmpa_q <= cmpa_wdata; // [R1] [R15]
      end
      if (cmpb_wr) begin
        cmpb_q <= cmpb_wdata; // [R1]
      end
    end
  end
  assign compare_a_value = cmpa_q;
  assign compare_b_value = cmpb_q;

  // matches, blocked for one tick after a counter write
  assign match_a = (cnt_q == cmpa_q) & ~block_q; // [R6] [R10]
  assign match_b = (cnt_q == cmpb_q) & ~block_q; // [R6] [R10]
  // a counter write in the same cycle means the counter never wraps from FF to 00
  assign ovf_evt = tick & ~cnt_wr & (cnt_q == EBT_MAX); // [R12] [R16] [R5]

  // counter next value
  always_comb begin
    cnt_d = cnt_q;
    if (cnt_wr) begin
      cnt_d = cnt_wdata; // [R5] [R4]
    end else if (tick) begin
      if (clear_on_match_select_q && match_a) begin
        cnt_d = EBT_BOTTOM; // [R14]
      end else begin
        cnt_d = cnt_q + 8'h01; // [R11] [R15]
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_q <= EBT_CNT_RST;
    end else if (clk_en) begin
      cnt_q <= cnt_d; // [R1]
    end
  end
  assign counter_value = cnt_q;

  // block holds from a counter write until the next tick has passed
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      block_q <= 1'b0;
    end else if (clk_en) begin
      if (cnt_wr) begin
        block_q <= 1'b1; // [R10]
      end else if (tick) begin
        block_q <= 1'b0;
      end
    end
  end

  // flags: set wins over any clear in the same cycle
  always_comb begin
    set_evt = 3'h0;
    set_evt[EBT_FLG_OVF] = ovf_evt;
    set_evt[EBT_FLG_MA]  = tick & match_a; // [R6]
    set_evt[EBT_FLG_MB]  = tick & match_b; // [R6]
    clr_evt = irq_taken | (flag_wr ? flag_wdata : 3'h0); // [R7] [R8] [R13]
    flag_d  = (flag_q & ~clr_evt) | set_evt;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flag_q <= EBT_FLG_RST;
    end else if (clk_en) begin
      flag_q <= flag_d;
    end
  end
  assign timer_flag_register = flag_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mask_q <= EBT_FLG_RST;
    end else if (clk_en && mask_wr) begin
      mask_q <= mask_wdata;
    end
  end
  assign timer_mask_register = mask_q;

  assign irq_overflow = flag_q[EBT_FLG_OVF] & mask_q[EBT_FLG_OVF]; // [R9]
  assign irq_match_a  = flag_q[EBT_FLG_MA] & mask_q[EBT_FLG_MA];   // [R9]
  assign irq_match_b  = flag_q[EBT_FLG_MB] & mask_q[EBT_FLG_MB];   // [R9]

  // checks
  chk_stop_holds: assert property (@(posedge ref_clk) disable iff (reset) // [R2]
    (clk_en && !cnt_wr && tick_source_select_q == EBT_CS_STOP) |=> $stable(cnt_q))
    else $error("counter moved while stopped");
  chk_write_wins: assert property (@(posedge ref_clk) disable iff (reset) // [R5]
    (clk_en && cnt_wr) |=> (cnt_q == $past(cnt_wdata)))
    else $error("counter write lost");
  chk_normal_inc: assert property (@(posedge ref_clk) disable iff (reset) // [R11]
    (clk_en && tick && !cnt_wr && !clear_on_match_select_q) |=> (cnt_q == $past(cnt_q) + 8'h01))
    else $error("normal mode did not increment");
  chk_ctc_clear: assert property (@(posedge ref_clk) disable iff (reset) // [R14]
    (clk_en && tick && !cnt_wr && clear_on_match_select_q && cnt_q == cmpa_q && !block_q)
    |=> (cnt_q == 8'h00))
    else $error("no clear on compare A");
  chk_ovf_set: assert property (@(posedge ref_clk) disable iff (reset) // [R12]
    (clk_en && tick && !cnt_wr && cnt_q == 8'hFF) |=> flag_q[EBT_FLG_OVF])
    else $error("overflow flag not set");
  chk_match_block: assert property (@(posedge ref_clk) disable iff (reset) // [R10]
    (clk_en && cnt_wr) ##1 (clk_en && tick && !flag_q[EBT_FLG_MB] && !cnt_wr)
    |=> !flag_q[EBT_FLG_MB])
    else $error("match not blocked after write");
  chk_flag_w1c: assert property (@(posedge ref_clk) disable iff (reset) // [R8]
    (clk_en && flag_wr && flag_wdata[EBT_FLG_MA] && !(tick && match_a))
    |=> !flag_q[EBT_FLG_MA])
    else $error("write one did not clear");
  chk_irq_mask: assert property (@(posedge ref_clk) disable iff (reset) // [R9]
    irq_match_b == (flag_q[EBT_FLG_MB] && mask_q[EBT_FLG_MB]))
    else $error("interrupt not gated by mask");
  chk_power_gate: assert property (@(posedge ref_clk) disable iff (reset) // [R17]
    (timer_power_gate && !cnt_wr) |=> $stable(cnt_q))
    else $error("counter moved while gated");
  chk_ctl_rsvd: assert property (@(posedge ref_clk) disable iff (reset) // [R22]
    timer_control_register[7:4] == 4'h0)
    else $error("reserved bits not zero");

  chk_freeze_all: assert property (@(posedge ref_clk) disable iff (reset) // [R24]
    !clk_en |=> ($stable(cnt_q) && $stable(flag_q) && $stable(mask_q) && $stable(block_q)))
    else $error("state moved while clock enable low");
  chk_freeze_regs: assert property (@(posedge ref_clk) disable iff (reset) // [R24]
    !clk_en |=> ($stable(cmpa_q) && $stable(cmpb_q) && $stable(timer_control_register)))
    else $error("register moved while clock enable low");
  chk_stop_no_tick: assert property (@(posedge ref_clk) disable iff (reset) // [R2]
    (tick_source_select_q == EBT_CS_STOP) |-> !tick)
    else $error("tick while no source selected");
  chk_gate_no_tick: assert property (@(posedge ref_clk) disable iff (reset) // [R17]
    timer_power_gate |-> !tick)
    else $error("tick while power gated");
  chk_div1_tick: assert property (@(posedge ref_clk) disable iff (reset) // [R20]
    (clk_en && !timer_power_gate && tick_source_select_q == EBT_CS_DIV1) |-> tick)
    else $error("undivided source missed a tick");
  chk_match_a_set: assert property (@(posedge ref_clk) disable iff (reset) // [R6]
    (tick && !block_q && cnt_q == cmpa_q) |=> flag_q[EBT_FLG_MA])
    else $error("compare A flag not set");
  chk_match_b_set: assert property (@(posedge ref_clk) disable iff (reset) // [R6]
    (tick && !block_q && cnt_q == cmpb_q) |=> flag_q[EBT_FLG_MB])
    else $error("compare B flag not set");
  chk_block_both: assert property (@(posedge ref_clk) disable iff (reset) // [R10]
    (tick && block_q && flag_q[EBT_FLG_MB:EBT_FLG_MA] == 2'b00)
    |=> (flag_q[EBT_FLG_MB:EBT_FLG_MA] == 2'b00))
    else $error("match flagged in blocked tick");
  chk_taken_clear_a: assert property (@(posedge ref_clk) disable iff (reset) // [R7]
    (clk_en && irq_taken[EBT_FLG_MA] && !(tick && match_a)) |=> !flag_q[EBT_FLG_MA])
    else $error("taken interrupt did not clear flag A");
  chk_taken_clear_b: assert property (@(posedge ref_clk) disable iff (reset) // [R7]
    (clk_en && irq_taken[EBT_FLG_MB] && !(tick && match_b)) |=> !flag_q[EBT_FLG_MB])
    else $error("taken interrupt did not clear flag B");
  chk_ovf_taken: assert property (@(posedge ref_clk) disable iff (reset) // [R13]
    (clk_en && irq_taken[EBT_FLG_OVF] && !ovf_evt) |=> !flag_q[EBT_FLG_OVF])
    else $error("taken interrupt did not clear overflow");
  chk_ovf_only: assert property (@(posedge ref_clk) disable iff (reset) // [R12]
    (!flag_q[EBT_FLG_OVF] && !(tick && !cnt_wr && cnt_q == EBT_MAX)) |=> !flag_q[EBT_FLG_OVF])
    else $error("overflow flag set without wrap");
  chk_max_wrap: assert property (@(posedge ref_clk) disable iff (reset) // [R11] [R16]
    (tick && !cnt_wr && cnt_q == EBT_MAX) |=> (cnt_q == EBT_BOTTOM))
    else $error("counter did not wrap to zero");

  cov_ctc_wrap: cover property (@(posedge ref_clk) disable iff (reset)
    clear_on_match_select_q && tick && match_a);
  cov_ovf: cover property (@(posedge ref_clk) disable iff (reset) ovf_evt);
  cov_ext: cover property (@(posedge ref_clk) disable iff (reset)
    tick && tick_source_select_q == EBT_CS_EXT_RISE);
  cov_blocked: cover property (@(posedge ref_clk) disable iff (reset)
    tick && block_q && cnt_q == cmpb_q);
endmodule : ebt_timer

// ===== bench/ebt_pin_model.sv
// count pin model standing in for the outside world
`timescale 1ns/100ps
module ebt_pin_model (
  input  wire logic ref_clk,
  output logic      external_count_pin
);
  initial external_count_pin = 1'b0;
  // each level is held six cycles, past the sync and edge delay
  task automatic drive(input logic lvl);
    @(posedge ref_clk);
    external_count_pin <= lvl;
    repeat (6) @(posedge ref_clk);
  endtask : drive
endmodule : ebt_pin_model

// ===== bench/tb.sv
// self-checking testbench for the timer
`timescale 1ns/100ps
module tb;
  import ebt_pkg::*;
  logic       ref_clk = 1'b0;
  logic       reset   = 1'b1;
  logic       en      = 1'b1;
  logic       gate    = 1'b0;
  logic       w_ctl   = 1'b0;
  logic       w_cnt   = 1'b0;
  logic       w_ca    = 1'b0;
  logic       w_cb    = 1'b0;
  logic       w_flg   = 1'b0;
  logic       w_msk   = 1'b0;
  logic [2:0] taken   = 3'h0;
  logic [7:0] wd      = 8'h00;
  logic [7:0] ctl;
  logic [7:0] cnt;
  logic [7:0] ca;
  logic [7:0] cb;
  logic [2:0] flg;
  logic [2:0] msk;
  logic       io;
  logic       ia;
  logic       ib;
  logic       tk;
  logic       pin;
  int         errors = 0;
  int         checks_done = 0;

  always #50 ref_clk = ~ref_clk;

  ebt_pin_model u_pin (.ref_clk(ref_clk), .external_count_pin(pin));

  ebt_timer u_ebt_timer (
    .ref_clk(ref_clk), .reset(reset), .clk_en(en), .timer_power_gate(gate),
    .external_count_pin(pin), .ctl_wr(w_ctl), .ctl_wdata(wd),
    .timer_control_register(ctl), .cnt_wr(w_cnt), .cnt_wdata(wd), .counter_value(cnt),
    .cmpa_wr(w_ca), .cmpa_wdata(wd), .compare_a_value(ca),
    .cmpb_wr(w_cb), .cmpb_wdata(wd), .compare_b_value(cb),
    .flag_wr(w_flg), .flag_wdata(wd[2:0]), .timer_flag_register(flg),
    .mask_wr(w_msk), .mask_wdata(wd[2:0]), .timer_mask_register(msk),
    .irq_taken(taken), .irq_overflow(io), .irq_match_a(ia),
    .irq_match_b(ib), .timer_tick(tk)
  );

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkn(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkn

  // strobe 0..5 writes a register, 6 reports interrupts taken
  task automatic strobe(input int sel, input logic v, input logic [2:0] d);
    case (sel)
      0: w_ctl <= v;
      1: w_cnt <= v;
      2: w_ca  <= v;
      3: w_cb  <= v;
      4: w_flg <= v;
      5: w_msk <= v;
      default: taken <= v ? d : 3'h0;
    endcase
  endtask : strobe

  task automatic wreg(input int sel, input logic [7:0] d);
    @(posedge ref_clk);
    wd <= d;
    strobe(sel, 1'b1, d[2:0]);
    @(posedge ref_clk);
    strobe(sel, 1'b0, d[2:0]);
    #1;
  endtask : wreg

  task automatic tick_count(input int n, output int c);
    c = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      #1;
      if (tk === 1'b1) c++;
    end
  endtask : tick_count

  // one full pulse on the count pin
  task automatic step;
    u_pin.drive(1'b1);
    u_pin.drive(1'b0);
    #1;
  endtask : step

  task automatic t_reset;
    chk(cnt, EBT_CNT_RST);
    chk(ca, EBT_CMP_RST);
    chk(ctl, EBT_CTL_RST);
    chk(flg, EBT_FLG_RST);
    wreg(0, 8'hF8);
    chk(ctl, 8'h08);
    wreg(3, 8'hA5);
    chk(cb, 8'hA5);
    wreg(0, 8'h00);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_stop;
    int c;
    wreg(1, 8'h77);
    tick_count(20, c);
    chkn(c, 0);
    chk(cnt, 8'h77);
    $display("t_stop done");
  endtask : t_stop

  task automatic t_pre;
    int c;
    int dv[5] = '{1, EBT_DIV_8, EBT_DIV_64, EBT_DIV_256, EBT_DIV_1024};
    for (int s = 1; s <= 5; s++) begin
      wreg(0, 8'(s));
      tick_count(2048, c);
      chkn(c, 2048 / dv[s-1]);
    end
    $display("t_pre done");
  endtask : t_pre

  task automatic t_prio;
    int c;
    wreg(0, 8'h01);
    wreg(1, 8'h40);
    chk(cnt, 8'h40);
    @(posedge ref_clk);
    #1;
    chk(cnt, 8'h41);
    @(posedge ref_clk);
    gate <= 1'b1;
    repeat (2) @(posedge ref_clk);
    tick_count(20, c);
    chkn(c, 0);
    wreg(1, 8'h09);
    tick_count(3, c);
    chk(cnt, 8'h09);
    @(posedge ref_clk);
    gate <= 1'b0;
    wreg(0, 8'h00);
    $display("t_prio done");
  endtask : t_prio

  // clock enable low freezes counting and ignores writes
  task automatic t_freeze;
    int c;
    wreg(0, 8'h01);
    wreg(1, 8'h10);
    @(posedge ref_clk);
    en <= 1'b0;
    tick_count(10, c);
    chkn(c, 0);
    chk(cnt, 8'h11);
    wreg(1, 8'h55);
    chk(cnt, 8'h11);
    @(posedge ref_clk);
    en <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk(cnt, 8'h12);
    wreg(0, 8'h00);
    $display("t_freeze done");
  endtask : t_freeze

  task automatic t_ext;
    wreg(0, 8'h07);
    wreg(1, 8'h00);
    u_pin.drive(1'b1);
    #1;
    chk(cnt, 8'h01);
    u_pin.drive(1'b0);
    #1;
    chk(cnt, 8'h01);
    wreg(0, 8'h06);
    u_pin.drive(1'b1);
    #1;
    chk(cnt, 8'h01);
    u_pin.drive(1'b0);
    #1;
    chk(cnt, 8'h02);
    $display("t_ext done");
  endtask : t_ext

  task automatic t_match;
    wreg(0, 8'h07);
    wreg(2, 8'h02);
    chk(ca, 8'h02);
    wreg(3, 8'h80);
    wreg(4, 8'h07);
    wreg(1, 8'h00);
    step;
    step;
    chk(flg, 3'h0);
    step;
    chk(flg, 3'h2);
    chk(ia, 1'b0);
    wreg(5, 8'h02);
    chk(msk, 8'h02);
    chk(ia, 1'b1);
    wreg(4, 8'h00);
    chk(flg, 3'h2);
    wreg(4, 8'h02);
    chk(flg, 3'h0);
    $display("t_match done");
  endtask : t_match

  task automatic t_block;
    wreg(0, 8'h00);
    wreg(3, 8'h05);
    wreg(1, 8'h05);
    wreg(0, 8'h07);
    step;
    chk(cnt, 8'h06);
    chk(flg, 3'h0);
    wreg(1, 8'h04);
    step;
    step;
    chk(flg, 3'h4);
    wreg(5, 8'h04);
    chk(ib, 1'b1);
    wreg(6, 8'h04);
    chk(flg, 3'h0);
    $display("t_block done");
  endtask : t_block

  task automatic t_ovf;
    wreg(5, 8'h01);
    wreg(1, 8'hFE);
    step;
    chk(flg, 3'h0);
    step;
    chk(cnt, 8'h00);
    chk(flg, 3'h1);
    chk(io, 1'b1);
    wreg(6, 8'h01);
    chk(flg, 3'h0);
    $display("t_ovf done");
  endtask : t_ovf

  task automatic t_ctc;
    wreg(0, 8'h0F);
    wreg(2, 8'h03);
    wreg(1, 8'h00);
    repeat (4) step;
    chk(cnt, 8'h00);
    chk(flg, 3'h2);
    wreg(4, 8'h07);
    wreg(1, 8'hFD);
    wreg(2, 8'h02);
    repeat (3) step;
    chk(flg, 3'h1);
    repeat (3) step;
    chk(cnt, 8'h00);
    chk(flg, 3'h3);
    $display("t_ctc done");
  endtask : t_ctc

  initial begin
    repeat (100000) @(posedge ref_clk);
    errors++;
    end_of_test;
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    t_reset;
    t_stop;
    t_pre;
    t_prio;
    t_freeze;
    t_ext;
    t_match;
    t_block;
    t_ovf;
    t_ctc;
    end_of_test;
  end
endmodule : tb
